// ==== core/prb_pkg.sv ====
package prb_pkg;
  localparam int unsigned PRB_WIDTH     = 7;
  localparam int unsigned PRB_TAP_HI    = 6;
  localparam int unsigned PRB_TAP_LO    = 5;
  localparam int unsigned PRB_PERIOD    = 127;
  localparam logic [6:0]  PRB_SEED      = 7'h7f;
  localparam logic [6:0]  PRB_ZERO      = 7'h00;
  localparam logic [6:0]  PRB_PER_LAST  = 7'h7e;
  localparam logic [6:0]  PRB_PER_ZERO  = 7'h00;
  localparam logic [6:0]  PRB_PER_ONE   = 7'h01;
  localparam logic [1:0]  PRB_CLKDIV_LAST = 2'h1;
  localparam logic [1:0]  PRB_CLKDIV_ZERO = 2'h0;
  localparam logic [1:0]  PRB_CLKDIV_ONE  = 2'h1;

  typedef enum logic [1:0] {
    PRB_IDLE = 2'h0,
    PRB_LOAD = 2'h1,
    PRB_RUN  = 2'h3
  } prb_state_e;
endpackage : prb_pkg

// ==== core/prb_step_if.sv ====
interface prb_step_if;
  logic       step;
  logic       load;
  logic [6:0] state;
  logic       bit_out;
  logic       period_mark;

  modport ctrl (
    output step,
    output load,
    input  state,
    input  bit_out,
    input  period_mark
  );
  modport lfsr (
    input  step,
    input  load,
    output state,
    output bit_out,
    output period_mark
  );
endinterface : prb_step_if

// ==== core/prb_lfsr.sv ====
module prb_lfsr
  import prb_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  prb_step_if.lfsr  sif
);
  logic [6:0] sr_q;
  logic [6:0] sr_d;
  logic [6:0] cnt_q;
  logic       fb;

  assign fb = sr_q[PRB_TAP_HI] ^ sr_q[PRB_TAP_LO]; // R02

  always_comb begin
    sr_d = sr_q;
    if (sif.load) begin
      sr_d = PRB_SEED; // R07
    end else if (sif.step) begin
      if (sr_q == PRB_ZERO) begin
        sr_d = PRB_SEED; // R07
      end else begin
        sr_d = {sr_q[PRB_WIDTH-2:0], fb}; // R01
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= PRB_SEED; // R07
    end else begin
      sr_q <= sr_d;
    end
  end

  // position within the 127-state cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= PRB_PER_ZERO;
    end else if (sif.load) begin
      cnt_q <= PRB_PER_ZERO;
    end else if (sif.step) begin
      cnt_q <= (cnt_q == PRB_PER_LAST) ? PRB_PER_ZERO : cnt_q + PRB_PER_ONE; // R03
    end
  end

  assign sif.state       = sr_q;
  assign sif.bit_out     = sr_q[PRB_TAP_HI];
  assign sif.period_mark = (cnt_q == PRB_PER_ZERO);
endmodule : prb_lfsr

// ==== core/prb_gen.sv ====
// Overview of operation
// R01: seven-stage shift register, XOR feedback, one step/clock
// R02: feedback is stage six XOR stage seven
// R03: maximal length, repeats every 127 bit clocks
// R04: longest runs: seven ones, six zeros
// R05: data and shifting clock output as LVDS pairs
// R06: runs only when enabled and option fitted
// R07: nonzero seed on reset/enable; escape all-zero state
module prb_gen
  import prb_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic gen_enable,
  input  wire logic option_fitted,
  output logic      data_p,
  output logic      data_n,
  output logic      bitclk_p,
  output logic      bitclk_n,
  output logic      running,
  output logic      period_start
);
  prb_step_if sif ();

  prb_state_e state_q;
  prb_state_e state_d;
  logic       en_meta_q;
  logic       en_sync_q;
  logic       fit_meta_q;
  logic       fit_sync_q;
  logic       go;
  logic       in_run;
  logic       in_load;
  logic       stuck;
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic       tick;
  logic       bit_start;
  logic       run_q;
  logic       data_q;
  logic       data_n_q;
  logic       data_d;
  logic       bitclk_q;
  logic       bitclk_n_q;
  logic       bitclk_d;
  logic       mark_q;
  logic       mark_d;

  // enable comes from outside this clock; two flops before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_meta_q <= 1'h0;
      en_sync_q <= 1'h0;
    end else begin
      en_meta_q <= gen_enable;
      en_sync_q <= en_meta_q;
    end
  end

  // option strap is a pin as well; same treatment
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fit_meta_q <= 1'h0;
      fit_sync_q <= 1'h0;
    end else begin
      fit_meta_q <= option_fitted;
      fit_sync_q <= fit_meta_q;
    end
  end

  assign go      = en_sync_q & fit_sync_q; // R06
  assign in_run  = (state_q == PRB_RUN);
  assign in_load = (state_q == PRB_LOAD);

  // an all-zero register would never leave zero; go back through load
  assign stuck = in_run && (sif.state == PRB_ZERO); // R07

  // idle, one cycle to load the seed, then run while enable and option hold
  always_comb begin
    state_d = state_q;
    case (state_q)
      PRB_IDLE: begin
        if (go) begin
          state_d = PRB_LOAD; // R07
        end
      end
      PRB_LOAD: begin
        if (go) begin
          state_d = PRB_RUN;
        end else begin
          state_d = PRB_IDLE;
        end
      end
      PRB_RUN: begin
        if (!go) begin
          // finish the bit on the wire so no runt clock pulse goes out
          if (tick) begin
            state_d = PRB_IDLE; // R06
          end
        end else if (stuck) begin
          state_d = PRB_LOAD; // R07
        end
      end
      default: begin
        state_d = PRB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PRB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // status flop follows the next state so it matches in_run cycle for cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'h0;
    end else begin
      run_q <= (state_d == PRB_RUN); // R06
    end
  end

  // bit clock at half the system rate: high half then low half
  always_comb begin
    div_d = div_q;
    if (!in_run) begin
      div_d = PRB_CLKDIV_ZERO;
    end else if (div_q == PRB_CLKDIV_LAST) begin
      div_d = PRB_CLKDIV_ZERO;
    end else begin
      div_d = div_q + PRB_CLKDIV_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= PRB_CLKDIV_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  // bit_start opens a bit period, tick closes it and advances the register
  assign bit_start = in_run && (div_q == PRB_CLKDIV_ZERO);
  assign tick      = in_run && (div_q == PRB_CLKDIV_LAST);
  assign sif.step  = tick; // R01
  assign sif.load  = in_load; // R07

  // steps or reloads the register; reports its state and period position
  prb_lfsr u_lfsr (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .sif     (sif)
  );

  // bit clock rises with each new bit, so its falling edge lands mid-bit
  always_comb begin
    bitclk_d = 1'h0;
    if (bit_start) begin
      bitclk_d = 1'h1; // R05
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bitclk_q   <= 1'h0;
      bitclk_n_q <= 1'h1;
    end else begin
      bitclk_q   <= bitclk_d;
      bitclk_n_q <= ~bitclk_d; // R05
    end
  end

  // data takes the next bit as the clock rises and holds it for both halves
  always_comb begin
    data_d = data_q;
    if (!in_run) begin
      data_d = 1'h0;
    end else if (bit_start) begin
      data_d = sif.bit_out; // R03 R04
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_q   <= 1'h0;
      data_n_q <= 1'h1;
    end else begin
      data_q   <= data_d;
      data_n_q <= ~data_d; // R05
    end
  end

  // period marker rides the high half of the first bit of each period
  always_comb begin
    mark_d = 1'h0;
    if (bit_start) begin
      mark_d = sif.period_mark; // R03
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mark_q <= 1'h0;
    end else begin
      mark_q <= mark_d;
    end
  end

  // each pin of a pair has its own flop so both sides switch on one edge
  assign data_p       = data_q; // R05
  assign data_n       = data_n_q;
  assign bitclk_p     = bitclk_q;
  assign bitclk_n     = bitclk_n_q;
  assign running      = run_q;
  assign period_start = mark_q;
endmodule : prb_gen

// ==== dv/prb_rx_model.sv ====
module prb_rx_model (
  input  logic bitclk_p,
  input  logic data_p,
  output int   rx_cnt,
  output logic rx_bit
);
  timeunit 1ns / 1ns;
  initial rx_cnt = 0;
  // sample mid-bit, away from the data update
  always @(negedge bitclk_p) begin
    rx_bit <= data_p;
    rx_cnt <= rx_cnt + 1;
  end
endmodule : prb_rx_model

// ==== dv/prb_gen_asserts.sv ====
module prb_gen_asserts (
  input logic clk_sys,
  input logic reset_n,
  input logic gen_enable,
  input logic option_fitted,
  input logic data_p,
  input logic data_n,
  input logic bitclk_p,
  input logic bitclk_n,
  input logic running,
  input logic period_start
);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_off;
    !(gen_enable && option_fitted);
  endsequence
  a_pairs_compl: assert property (data_n != data_p && bitclk_n != bitclk_p)
    else $error("pair");
  a_clock_toggles: assert property (running [*2] |-> bitclk_p != $past(bitclk_p))
    else $error("toggle");
  a_data_on_rise: assert property (running && $changed(data_p) |-> $rose(bitclk_p))
    else $error("edge");
  a_mark_seed: assert property (period_start |-> bitclk_p && data_p)
    else $error("mark");
  a_period_gap: assert property ($rose(period_start) |-> ##254 (period_start || !running))
    else $error("period");
  a_start_delay: assert property ($rose(gen_enable && option_fitted) |-> ##[3:5] running)
    else $error("start");
  a_off_idle: assert property (s_off [*5] |-> !running)
    else $error("stop");
endmodule : prb_gen_asserts

bind prb_gen prb_gen_asserts u_chk (.*);

// ==== dv/prb_gen_tb.sv ====
module prb_gen_tb import prb_pkg::*; ();
  timeunit 1ns / 1ns;
  logic clk_sys = 0, reset_n = 0, gen_enable = 0, option_fitted = 0;
  logic data_p, data_n, bitclk_p, bitclk_n, running, period_start, rx_bit;
  int   rx_cnt, bad_count = 0, n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  prb_gen i_dut (.*);
  prb_rx_model i_rx (.*);
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %h %h", $time, got, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // expected stream rebuilt from the seed
  task automatic run_seq(input int n);
    logic [6:0] s = PRB_SEED;
    logic       seen;
    int c;
    for (int i = 0; i < n; i++) begin
      c = rx_cnt;
      seen = 1'h0;
      for (int t = 0; t < 8 && rx_cnt == c; t++) begin
        @(negedge clk_sys);
        seen = seen | period_start;
      end
      if (rx_cnt == c) begin
        check(8'h00, 8'h01);
        stop_test();
      end else begin
        check(8'(rx_bit), 8'(s[6]));
        check(8'(seen), 8'(i % PRB_PERIOD == 0));
      end
      s = {s[5:0], s[6] ^ s[5]};
    end
  endtask : run_seq
  task sc_start;
    @(posedge clk_sys);
    gen_enable <= 1'h1;
    option_fitted <= 1'h1;
    run_seq(254);
  endtask : sc_start
  task sc_restart;
    @(posedge clk_sys);
    option_fitted <= 1'h0;
    repeat (8) @(negedge clk_sys);
    check(8'({running, bitclk_p, bitclk_n, data_p, data_n, period_start}), 8'h0a);
    @(posedge clk_sys);
    option_fitted <= 1'h1;
    run_seq(9);
  endtask : sc_restart
  task sc_enable_drop;
    @(posedge clk_sys);
    gen_enable <= 1'h0;
    repeat (8) @(negedge clk_sys);
    check(8'({running, bitclk_p, bitclk_n, data_p, data_n, period_start}), 8'h0a);
    @(posedge clk_sys);
    gen_enable <= 1'h1;
    run_seq(9);
  endtask : sc_enable_drop
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    sc_start();
    sc_restart();
    sc_enable_drop();
    stop_test();
  end
endmodule : prb_gen_tb
